// >>> bench/arf_top_properties.sv
// Concurrent checks on the result formatter's register port and status outputs.
`timescale 1ns/10ps
module arf_top_properties
  import arf_pkg::*;
(
  input wire logic                       sys_clk,        // Clock.
  input wire logic                       rst_n,          // Reset.
  input wire logic [arf_pkg::ADDR_W-1:0] reg_addr,       // Index.
  input wire logic [arf_pkg::DATA_W-1:0] reg_wdata,      // Write data.
  input wire logic                       reg_wr,         // Write.
  input wire logic                       reg_rd,         // Read.
  input wire logic [arf_pkg::DATA_W-1:0] reg_rdata,      // Read data.
  input wire logic                       temp_sensor_en, // Sensor on.
  input wire logic                       busy,           // Converting.
  input wire logic                       irq             // Interrupt.
);
  import arf_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic start_w;
  logic wr_ch;
  logic is_temp;
  assign start_w = reg_wr && reg_addr == ADDR_CSA && reg_wdata[CSA_EN_BIT]
                   && reg_wdata[CSA_START_BIT] && !busy;
  assign wr_ch   = reg_wr && reg_addr == ADDR_CHSEL;
  assign is_temp = reg_wdata[SEL_W-1:0] == SEL_TEMP;
  AST_START_BUSY: assert property (start_w |-> ##[1:2] busy)
    else $error("busy missing after start");
  AST_BUSY_SPAN: assert property ($rose(busy) |-> busy[*8] ##1 busy[*4])
    else $error("busy ended early");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(start_w) || $past(start_w, 2))
    else $error("busy without start");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(busy) || $past(reg_wr))
    else $error("irq without completion");
  AST_TEMP_SET: assert property (wr_ch && is_temp ##1 !wr_ch |-> ##[0:1] temp_sensor_en)
    else $error("sensor not enabled");
  AST_TEMP_CAUSE: assert property ($changed(temp_sensor_en) |-> $past(wr_ch) || $past(wr_ch, 2))
    else $error("sensor changed alone");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  AST_RESH_UPPER: assert property (reg_rd && reg_addr == ADDR_RESH |=> reg_rdata[7:2] == 6'h00)
    else $error("high result upper bits set");
  AST_WO_READ: assert property (reg_rd && reg_addr >= ADDR_IRQ_CLR && reg_addr != ADDR_IRQ_EN
                                |=> reg_rdata == 8'h00)
    else $error("unreadable index returned data");
  cover property ($rose(busy));
  cover property ($rose(irq));
  cover property ($rose(temp_sensor_en));
endmodule
bind arf_top arf_top_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .temp_sensor_en(temp_sensor_en), .busy(busy), .irq(irq));

// >>> bench/testbench.sv
// Self-checking bench for the converter result formatter.
`timescale 1ns/10ps
module testbench;
  import arf_pkg::*;
  logic                         sys_clk   = 1'b0;
  logic                         rst_n     = 1'b0;
  logic [ADDR_W-1:0]            reg_addr  = 4'h0;
  logic [DATA_W-1:0]            reg_wdata = 8'h00;
  logic                         reg_wr    = 1'b0;
  logic                         reg_rd    = 1'b0;
  logic [DATA_W-1:0]            reg_rdata;
  logic [CH_NUM-1:0][LVL_W-1:0] lvl;
  logic                         temp_sensor_en;
  logic                         busy;
  logic                         irq;
  int                           err_total = 0;
  int                           compares  = 0;
  logic [9:0]                   code;
  logic [7:0]                   st;
  logic [7:0]                   d;
  logic                         iq;
  always #2.5 sys_clk = ~sys_clk;
  arf_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_level(lvl),
    .ref_vcc_level(12'h400), .ref_ext_level(12'h800), .temp_sensor_en(temp_sensor_en),
    .busy(busy), .irq(irq));
  task automatic end_sim();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Inputs stay still for the whole conversion so the result is settled.
  task automatic fin(output logic [9:0] c, output logic [7:0] s);
    logic [7:0] lo;
    logic [7:0] hi;
    int         n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 40) begin
      err_total++;
      $display("mismatch %0t conversion never finished", $time);
      end_sim();
    end
    rd(ADDR_RESL, lo);
    rd(ADDR_RESH, hi);
    rd(ADDR_IRQ_STAT, s);
    iq = irq;
    c = {hi[1:0], lo};
    wr(ADDR_IRQ_CLR, 8'h03);
  endtask
  task automatic conv(input logic [7:0] ch, output logic [9:0] c, output logic [7:0] s);
    wr(ADDR_CHSEL, ch);
    wr(ADDR_CSA, 8'hc0);
    fin(c, s);
  endtask
  task automatic t_reset();
    rd(ADDR_CSB, d);
    chk(10'(d), 10'h000);
    chk(10'(temp_sensor_en), 10'h000);
    rd(ADDR_RESH, d);
    chk(10'(d), 10'h000);
  endtask
  task automatic t_single();
    logic [7:0] ch [4] = '{8'h03, 8'h43, 8'h20, 8'h05};
    logic [9:0] ex [4] = '{10'h123, 10'h091, 10'h000, 10'h3ff};
    for (int i = 0; i < 4; i++) begin
      conv(ch[i], code, st);
      chk(code, ex[i]);
      chk(10'(st[EV_DONE_BIT]), 10'h001);
    end
  endtask
  task automatic t_uni();
    conv(8'h08, code, st);
    chk(code, 10'h010);
    conv(8'h09, code, st);
    chk(code, 10'h140);
    conv(8'h28, code, st);
    chk(code, 10'h000);
    chk(10'(st[EV_CLAMP_BIT]), 10'h001);
    conv(8'h35, code, st);
    chk(code, 10'h3ff);
    chk(10'(st[EV_CLAMP_BIT]), 10'h001);
  endtask
  task automatic t_bip();
    wr(ADDR_CSB, 8'h80);
    rd(ADDR_CSB, d);
    chk(10'(d), 10'h080);
    conv(8'h28, code, st);
    chk(code, 10'h3f8);
    chk(10'(code[9]), 10'h001);
    conv(8'h09, code, st);
    chk(code, 10'h0a0);
    chk(10'(code[9]), 10'h000);
    conv(8'h15, code, st);
    chk(code, 10'h200);
    conv(8'h03, code, st);
    chk(code, 10'h123);
    wr(ADDR_CSB, 8'h00);
  endtask
  task automatic t_temp();
    conv(8'ha2, code, st);
    chk(10'(temp_sensor_en), 10'h001);
    chk(code, 10'h100);
    wr(ADDR_CHSEL, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk(10'(temp_sensor_en), 10'h000);
  endtask
  task automatic t_irq();
    wr(ADDR_IRQ_EN, 8'h01);
    conv(8'h03, code, st);
    chk(10'(iq), 10'h001);
    repeat (2) @(posedge sys_clk);
    #1 chk(10'(irq), 10'h000);
    wr(ADDR_IRQ_EN, 8'h00);
    conv(8'h08, code, st);
    chk(10'(iq), 10'h000);
    wr(ADDR_CHSEL, 8'h05);
    wr(ADDR_CSA, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1 chk(10'(busy), 10'h000);
    rd(ADDR_RESL, d);
    chk(10'(d), 10'h010);
    rd(4'hf, d);
    chk(10'(d), 10'h000);
  endtask
  // Free running keeps busy high across completions until it is switched off.
  task automatic t_free();
    wr(ADDR_CSB, 8'h80);
    wr(ADDR_CHSEL, 8'h35);
    wr(ADDR_CSA, 8'he0);
    repeat (20) @(posedge sys_clk);
    #1 chk(10'(busy), 10'h001);
    rd(ADDR_IRQ_STAT, d);
    chk(10'(d), 10'h003);
    wr(ADDR_CSA, 8'h00);
    fin(code, st);
    chk(code, 10'h1ff);
    chk(10'(busy), 10'h000);
    wr(ADDR_CSB, 8'h00);
  endtask
  initial begin
    lvl    = '0;
    lvl[0] = 12'h110;
    lvl[1] = 12'h100;
    lvl[3] = 12'h123;
    lvl[5] = 12'hfff;
    lvl[8] = 12'h113;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_uni();
    t_bip();
    t_temp();
    t_irq();
    t_free();
    end_sim();
  end
endmodule

// >>> rtl/arf_chan_decode.sv
// Channel, gain, polarity and reference decoder, locked at conversion start.
`timescale 1ns/10ps
module arf_chan_decode
  import arf_pkg::*;
(
  input  wire logic                                          clk,          // Clock.
  input  wire logic                                          rst_n,        // Async reset.
  input  wire logic                                          capture,      // Lock selection.
  input  wire logic [arf_pkg::SEL_W-1:0]                     input_select, // Channel code.
  input  wire logic [arf_pkg::REF_W-1:0]                     ref_sel,      // Reference code.
  input  wire logic                                          bipolar_in,   // Bipolar mode.
  input  wire logic [arf_pkg::CH_NUM-1:0][arf_pkg::LVL_W-1:0] analog_level, // Input levels.
  input  wire logic [arf_pkg::LVL_W-1:0]                     ref_vcc_level, // Supply ref.
  input  wire logic [arf_pkg::LVL_W-1:0]                     ref_ext_level, // External ref.
  arf_sel_if.src                                             sel           // Locked selection.
);
  import arf_pkg::*;

  function automatic arf_pair_t pair_of(input logic [3:0] idx);
    arf_pair_t p;
    p = '{pos: 4'h0, neg: 4'h0};
    case (idx)
      4'h4: p = '{pos: 4'h0, neg: 4'h1};
      4'h5: p = '{pos: 4'h0, neg: 4'h3};
      4'h6: p = '{pos: 4'h1, neg: 4'h2};
      4'h7: p = '{pos: 4'h1, neg: 4'h3};
      4'h8: p = '{pos: 4'h2, neg: 4'h3};
      4'h9: p = '{pos: 4'h3, neg: 4'h4};
      4'ha: p = '{pos: 4'h3, neg: 4'h5};
      4'hb: p = '{pos: 4'h3, neg: 4'h6};
      4'hc: p = '{pos: 4'h3, neg: 4'h7};
      4'hd: p = '{pos: 4'h4, neg: 4'h5};
      4'he: p = '{pos: 4'h5, neg: 4'h6};
      4'hf: p = '{pos: 4'h6, neg: 4'h7};
      default: p = '{pos: 4'h0, neg: 4'h0};
    endcase
    return p;
  endfunction

  function automatic logic [3:0] cal_ch(input logic [1:0] idx);
    case (idx)
      2'h2:    return 4'h3;
      2'h3:    return 4'h7;
      default: return 4'h0;
    endcase
  endfunction

  logic [LVL_W-1:0] pos_r, pos_nxt, neg_r, neg_nxt, ref_r, ref_nxt;
  logic             gain_r, gain_nxt, diff_r, diff_nxt, bip_r, bip_nxt;
  arf_pair_t        pr;
  logic [3:0]       cc;

  always_comb begin
    pr       = pair_of(input_select[4:1]);
    cc       = cal_ch(input_select[2:1]);
    pos_nxt  = pos_r;
    neg_nxt  = neg_r;
    ref_nxt  = ref_r;
    gain_nxt = gain_r;
    diff_nxt = diff_r;
    bip_nxt  = bip_r;
    if (capture) begin
      bip_nxt  = bipolar_in;
      gain_nxt = 1'b0;
      diff_nxt = 1'b0;
      neg_nxt  = LVL_ZERO;
      case (ref_sel)
        REF_VCC: ref_nxt = ref_vcc_level;
        REF_EXT: ref_nxt = ref_ext_level;
        default: ref_nxt = REF_INT_LEVEL;
      endcase
      if (input_select[5:3] == GRP_SINGLE) begin
        pos_nxt = analog_level[input_select[2:0]];
      end else if (input_select == SEL_AGND) begin
        pos_nxt = LVL_ZERO;
      end else if (input_select == SEL_IREF) begin
        pos_nxt = REF_INT_LEVEL;
      end else if (input_select == SEL_TEMP) begin
        pos_nxt = analog_level[TEMP_CH];
      end else if (input_select[5:3] == GRP_SPECIAL) begin
        pos_nxt  = analog_level[cc];
        neg_nxt  = analog_level[cc];
        diff_nxt = 1'b1;
        gain_nxt = input_select[0];
      end else begin
        diff_nxt = 1'b1;
        gain_nxt = input_select[0];
        if (input_select[5]) begin
          pos_nxt = analog_level[pr.neg];
          neg_nxt = analog_level[pr.pos];
        end else begin
          pos_nxt = analog_level[pr.pos];
          neg_nxt = analog_level[pr.neg];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r  <= LVL_ZERO;
      neg_r  <= LVL_ZERO;
      ref_r  <= LVL_ZERO;
      gain_r <= 1'b0;
      diff_r <= 1'b0;
      bip_r  <= 1'b0;
    end else begin
      pos_r  <= pos_nxt;
      neg_r  <= neg_nxt;
      ref_r  <= ref_nxt;
      gain_r <= gain_nxt;
      diff_r <= diff_nxt;
      bip_r  <= bip_nxt;
    end
  end

  assign sel.pos_level = pos_r;
  assign sel.neg_level = neg_r;
  assign sel.ref_level = ref_r;
  assign sel.gain20    = gain_r;
  assign sel.diff_mode = diff_r;
  assign sel.bipolar   = bip_r;
endmodule

// >>> rtl/arf_pkg.sv
// Shared constants, register map and types of the converter result formatter.
package arf_pkg;
  localparam int LVL_W     = 12;
  localparam int CH_NUM    = 9;
  localparam int TEMP_CH   = 8;
  localparam int CODE_W    = 10;
  localparam int QUOT_W    = 11;
  localparam int NUM_W     = 28;
  localparam int PROD_W    = 23;
  localparam int MAG_W     = 17;
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 8;
  localparam int SEL_W     = 6;
  localparam int REF_W     = 2;
  localparam int EV_N      = 2;
  localparam int SHIFT_UNI = 10;
  localparam int SHIFT_BIP = 9;

  localparam logic [MAG_W-1:0]  GAIN_HI       = 17'h00014;
  localparam logic [LVL_W-1:0]  REF_INT_LEVEL = 12'h44c;
  localparam logic [LVL_W-1:0]  LVL_ZERO      = 12'h000;

  localparam logic [SEL_W-1:0]  SEL_AGND = 6'h20;
  localparam logic [SEL_W-1:0]  SEL_IREF = 6'h21;
  localparam logic [SEL_W-1:0]  SEL_TEMP = 6'h22;
  localparam logic [2:0]        GRP_SINGLE = 3'h0;
  localparam logic [2:0]        GRP_SPECIAL = 3'h4;

  localparam logic [REF_W-1:0]  REF_VCC = 2'h0;
  localparam logic [REF_W-1:0]  REF_EXT = 2'h1;

  localparam logic [ADDR_W-1:0] ADDR_CHSEL    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CSA      = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CSB      = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_RESL     = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RESH     = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 4'h7;

  localparam int CSA_EN_BIT    = 7;
  localparam int CSA_START_BIT = 6;
  localparam int CSA_FREE_BIT  = 5;
  localparam int CSB_BIP_BIT   = 7;
  localparam int EV_DONE_BIT   = 0;
  localparam int EV_CLAMP_BIT  = 1;
  localparam int CHSEL_REF_LSB = 6;

  localparam logic [DATA_W-1:0] REG_RST   = 8'h00;
  localparam logic [EV_N-1:0]   EV_RST    = 2'h0;
  localparam logic [CODE_W-1:0] UNI_MAX     = 10'h3ff;
  localparam logic [CODE_W-1:0] BIP_POS_MAX = 10'h1ff;
  localparam logic [CODE_W-1:0] BIP_NEG_MIN = 10'h200;
  localparam logic [QUOT_W-1:0] Q_UNI_MAX   = 11'h3ff;
  localparam logic [QUOT_W-1:0] Q_BIP_POS   = 11'h1ff;
  localparam logic [QUOT_W-1:0] Q_BIP_NEG   = 11'h200;
  localparam logic [QUOT_W-1:0] Q_ZERO      = 11'h000;

  typedef enum logic [1:0] {SAR_IDLE, SAR_LOAD, SAR_STEP} arf_sar_state_t;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
  } arf_pair_t;
endpackage

// >>> rtl/arf_sar_core.sv
// Successive approximation of scaled input magnitude against the reference.
`timescale 1ns/10ps
module arf_sar_core
  import arf_pkg::*;
(
  input  wire logic                        clk,      // Clock.
  input  wire logic                        rst_n,    // Async reset.
  input  wire logic                        start,    // Begin conversion.
  arf_sel_if.dst                           sel,      // Locked selection.
  output logic                             done,     // One-cycle completion.
  output logic [arf_pkg::QUOT_W-1:0]       quot,     // Magnitude quotient.
  output logic                             negative, // Bipolar result below zero.
  output logic                             clamped,  // Unipolar difference clamped.
  output logic                             bip_mode  // Result is two's complement.
);
  import arf_pkg::*;

  arf_sar_state_t        state_r, state_nxt;
  logic [NUM_W-1:0]      num_r, num_nxt;
  logic [LVL_W-1:0]      vref_r, vref_nxt;
  logic [QUOT_W-1:0]     quot_r, quot_nxt, trial;
  logic [3:0]            idx_r, idx_nxt;
  logic                  neg_r, neg_nxt, clamp_r, clamp_nxt, bip_r, bip_nxt, done_r, done_nxt;
  logic signed [LVL_W:0] d;
  logic [LVL_W-1:0]      mag;
  logic [MAG_W-1:0]      magg;
  logic [PROD_W-1:0]     prod;

  always_comb begin
    state_nxt = state_r;
    num_nxt   = num_r;
    vref_nxt  = vref_r;
    quot_nxt  = quot_r;
    idx_nxt   = idx_r;
    neg_nxt   = neg_r;
    clamp_nxt = clamp_r;
    bip_nxt   = bip_r;
    done_nxt  = 1'b0;
    d     = $signed({1'b0, sel.pos_level}) - $signed({1'b0, sel.neg_level});
    mag   = sel.pos_level;
    trial = quot_r | (QUOT_W'(1) << idx_r);
    prod  = PROD_W'(trial) * PROD_W'(vref_r);
    magg  = MAG_W'(0);
    case (state_r)
      SAR_IDLE: begin
        if (start) begin
          state_nxt = SAR_LOAD;
        end
      end
      SAR_LOAD: begin
        neg_nxt   = 1'b0;
        clamp_nxt = 1'b0;
        bip_nxt   = sel.bipolar & sel.diff_mode;
        if (sel.diff_mode) begin
          if (d < 0) begin
            if (sel.bipolar) begin
              mag     = LVL_W'(-d);
              neg_nxt = 1'b1;
            end else begin
              mag       = LVL_ZERO;
              clamp_nxt = 1'b1;
            end
          end else begin
            mag = LVL_W'(d);
          end
        end
        magg = sel.gain20 ? MAG_W'(mag) * GAIN_HI : MAG_W'(mag);
        if (bip_nxt) begin
          num_nxt = NUM_W'(magg) << SHIFT_BIP;
        end else begin
          num_nxt = NUM_W'(magg) << SHIFT_UNI;
        end
        vref_nxt  = sel.ref_level;
        quot_nxt  = Q_ZERO;
        idx_nxt   = 4'(QUOT_W - 1);
        state_nxt = SAR_STEP;
      end
      SAR_STEP: begin
        if (NUM_W'(prod) <= num_r) begin
          quot_nxt = trial;
        end
        if (idx_r == 4'h0) begin
          done_nxt  = 1'b1;
          state_nxt = SAR_IDLE;
        end else begin
          idx_nxt = idx_r - 4'h1;
        end
      end
      default: state_nxt = SAR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SAR_IDLE;
      num_r   <= '0;
      vref_r  <= LVL_ZERO;
      quot_r  <= Q_ZERO;
      idx_r   <= 4'h0;
      neg_r   <= 1'b0;
      clamp_r <= 1'b0;
      bip_r   <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      num_r   <= num_nxt;
      vref_r  <= vref_nxt;
      quot_r  <= quot_nxt;
      idx_r   <= idx_nxt;
      neg_r   <= neg_nxt;
      clamp_r <= clamp_nxt;
      bip_r   <= bip_nxt;
      done_r  <= done_nxt;
    end
  end

  assign done     = done_r;
  assign quot     = quot_r;
  assign negative = neg_r;
  assign clamped  = clamp_r;
  assign bip_mode = bip_r;
endmodule

// >>> rtl/arf_sel_if.sv
// Locked input selection passed from the channel decoder to the approximation core.
`timescale 1ns/10ps
interface arf_sel_if;
  logic [arf_pkg::LVL_W-1:0] pos_level;
  logic [arf_pkg::LVL_W-1:0] neg_level;
  logic [arf_pkg::LVL_W-1:0] ref_level;
  logic                      gain20;
  logic                      diff_mode;
  logic                      bipolar;
  modport src (output pos_level, neg_level, ref_level, gain20, diff_mode, bipolar);
  modport dst (input  pos_level, neg_level, ref_level, gain20, diff_mode, bipolar);
endinterface

// >>> rtl/arf_top.sv
// Converter result formatter: registers, conversion control, formatting and interrupt.
// Function
// - Single-ended gives unsigned code, ground zero.
// - Single-ended code is input*1024/reference, truncated.
// - Unipolar differential saturates to zero when negative.
// - Differential gain is one or twenty.
// - Bipolar gives two's complement, difference*512*gain/reference.
// - Result sign bit in result_high marks negative.
// - Unipolar after reset; bipolar_select enables bipolar.
// - Result valid once conversion_complete_flag is high.
// - Code 100010 selects temperature channel, enables sensor.
// - gain_select_bit zero unity, one twentyfold.
// - polarity_swap_bit exchanges differential inputs.
// - Results and flag written in same cycle.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module arf_top
  import arf_pkg::*;
(
  input  wire logic                                          sys_clk,        // 200 MHz clock.
  input  wire logic                                          rst_n,          // Async reset.
  input  wire logic [arf_pkg::ADDR_W-1:0]                    reg_addr,       // Register index.
  input  wire logic [arf_pkg::DATA_W-1:0]                    reg_wdata,      // Write data.
  input  wire logic                                          reg_wr,         // Write strobe.
  input  wire logic                                          reg_rd,         // Read strobe.
  output logic      [arf_pkg::DATA_W-1:0]                    reg_rdata,      // Read data.
  input  wire logic [arf_pkg::CH_NUM-1:0][arf_pkg::LVL_W-1:0] analog_level,  // Input levels.
  input  wire logic [arf_pkg::LVL_W-1:0]                     ref_vcc_level,  // Supply ref.
  input  wire logic [arf_pkg::LVL_W-1:0]                     ref_ext_level,  // External ref.
  output logic                                               temp_sensor_en, // Sensor on.
  output logic                                               busy,           // Converting.
  output logic                                               irq             // Interrupt.
);
  import arf_pkg::*;

  logic [DATA_W-1:0] chsel_r, chsel_nxt;
  logic              en_r, en_nxt, free_r, free_nxt, busy_r, busy_nxt;
  logic              bip_sel_r, bip_sel_nxt, go_r, go_nxt;
  logic [DATA_W-1:0] resl_r, resl_nxt, resh_r, resh_nxt;
  logic [EV_N-1:0]   stat_r, stat_nxt, ien_r, ien_nxt, ev, clr;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              irq_r, irq_nxt, temp_r, temp_nxt;
  logic              wr_chsel, wr_csa, wr_csb, wr_clr, wr_ien;
  logic [CODE_W-1:0] code;
  logic              core_done, core_neg, core_clamp, core_bip, ovr;
  logic [QUOT_W-1:0] core_quot;

  arf_sel_if sel_bus ();

  arf_chan_decode u_decode (
    .clk           (sys_clk),
    .rst_n         (rst_n),
    .capture       (go_r),
    .input_select  (chsel_r[SEL_W-1:0]),
    .ref_sel       (chsel_r[CHSEL_REF_LSB +: REF_W]),
    .bipolar_in    (bip_sel_r),
    .analog_level  (analog_level),
    .ref_vcc_level (ref_vcc_level),
    .ref_ext_level (ref_ext_level),
    .sel           (sel_bus.src)
  );

  arf_sar_core u_core (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .start    (go_r),
    .sel      (sel_bus.dst),
    .done     (core_done),
    .quot     (core_quot),
    .negative (core_neg),
    .clamped  (core_clamp),
    .bip_mode (core_bip)
  );

  // Output code formatting with range saturation.
  always_comb begin
    ovr  = 1'b0;
    code = UNI_MAX;
    if (core_bip) begin
      if (core_neg) begin
        if (core_quot > Q_BIP_NEG) begin
          code = BIP_NEG_MIN;
          ovr  = 1'b1;
        end else begin
          code = CODE_W'(Q_ZERO - core_quot);
        end
      end else if (core_quot > Q_BIP_POS) begin
        code = BIP_POS_MAX;
        ovr  = 1'b1;
      end else begin
        code = CODE_W'(core_quot);
      end
    end else if (core_quot > Q_UNI_MAX) begin
      code = UNI_MAX;
      ovr  = 1'b1;
    end else begin
      code = CODE_W'(core_quot);
    end
  end

  always_comb begin
    wr_chsel = reg_wr && (reg_addr == ADDR_CHSEL);
    wr_csa   = reg_wr && (reg_addr == ADDR_CSA);
    wr_csb   = reg_wr && (reg_addr == ADDR_CSB);
    wr_clr   = reg_wr && (reg_addr == ADDR_IRQ_CLR);
    wr_ien   = reg_wr && (reg_addr == ADDR_IRQ_EN);
  end

  // Control and conversion sequencing.
  always_comb begin
    chsel_nxt   = wr_chsel ? reg_wdata : chsel_r;
    en_nxt      = wr_csa ? reg_wdata[CSA_EN_BIT] : en_r;
    free_nxt    = wr_csa ? reg_wdata[CSA_FREE_BIT] : free_r;
    bip_sel_nxt = wr_csb ? reg_wdata[CSB_BIP_BIT] : bip_sel_r;
    temp_nxt    = (chsel_nxt[SEL_W-1:0] == SEL_TEMP);
    go_nxt      = 1'b0;
    busy_nxt    = busy_r;
    if (core_done) begin
      busy_nxt = 1'b0;
      if (free_r && en_r) begin
        go_nxt   = 1'b1;
        busy_nxt = 1'b1;
      end
    end else if (!busy_r && wr_csa && reg_wdata[CSA_EN_BIT] && reg_wdata[CSA_START_BIT]) begin
      go_nxt   = 1'b1;
      busy_nxt = 1'b1;
    end
  end

  // Result registers change only on completion, together with the flag.
  always_comb begin
    resl_nxt = resl_r;
    resh_nxt = resh_r;
    ev       = EV_RST;
    if (core_done) begin
      resl_nxt = code[DATA_W-1:0];
      resh_nxt = {{(2 * DATA_W - CODE_W){1'b0}}, code[CODE_W-1:DATA_W]};
      ev[EV_DONE_BIT]  = 1'b1;
      ev[EV_CLAMP_BIT] = core_clamp | ovr;
    end
  end

  // Sticky events: a set in the same cycle as its clear wins.
  always_comb begin
    clr      = wr_clr ? reg_wdata[EV_N-1:0] : EV_RST;
    stat_nxt = (stat_r & ~clr) | ev;
    ien_nxt  = wr_ien ? reg_wdata[EV_N-1:0] : ien_r;
    irq_nxt  = |(stat_nxt & ien_nxt);
  end

  always_comb begin
    rdata_nxt = REG_RST;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CHSEL:    rdata_nxt = chsel_r;
        ADDR_CSA:      rdata_nxt = DATA_W'({en_r, busy_r, free_r}) << CSA_FREE_BIT;
        ADDR_CSB:      rdata_nxt = DATA_W'(bip_sel_r) << CSB_BIP_BIT;
        ADDR_RESL:     rdata_nxt = resl_r;
        ADDR_RESH:     rdata_nxt = resh_r;
        ADDR_IRQ_STAT: rdata_nxt = DATA_W'(stat_r);
        ADDR_IRQ_EN:   rdata_nxt = DATA_W'(ien_r);
        default:       rdata_nxt = REG_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chsel_r   <= REG_RST;
      en_r      <= 1'b0;
      free_r    <= 1'b0;
      busy_r    <= 1'b0;
      bip_sel_r <= 1'b0;
      go_r      <= 1'b0;
      resl_r    <= REG_RST;
      resh_r    <= REG_RST;
      stat_r    <= EV_RST;
      ien_r     <= EV_RST;
      rdata_r   <= REG_RST;
      irq_r     <= 1'b0;
      temp_r    <= 1'b0;
    end else begin
      chsel_r   <= chsel_nxt;
      en_r      <= en_nxt;
      free_r    <= free_nxt;
      busy_r    <= busy_nxt;
      bip_sel_r <= bip_sel_nxt;
      go_r      <= go_nxt;
      resl_r    <= resl_nxt;
      resh_r    <= resh_nxt;
      stat_r    <= stat_nxt;
      ien_r     <= ien_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      temp_r    <= temp_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign irq            = irq_r;
  assign busy           = busy_r;
  assign temp_sensor_en = temp_r;
endmodule
